// *** hdl/sac_pkg.sv ***
package sac_pkg;
  // ==========================================================
  // Register map, byte addresses on the APB bus
  localparam logic [7:0] OFS_CTRL_A = 8'h00;
  localparam logic [7:0] OFS_CTRL_B = 8'h04;
  localparam logic [7:0] OFS_CHREF = 8'h08;
  localparam logic [7:0] OFS_RES_LO = 8'h0c;
  localparam logic [7:0] OFS_RES_HI = 8'h10;
  // ==========================================================
  // control_status_a fields
  localparam int CA_EN = 7;
  localparam int CA_START = 6;
  localparam int CA_AUTO = 5;
  localparam int CA_FLAG = 4;
  localparam int CA_IE = 3;
  localparam int CA_DIV_HI = 2;
  // channel_reference_reg fields
  localparam int CR_REF_HI = 7;
  localparam int CR_REF_LO = 6;
  localparam int CR_LADJ = 5;
  localparam int CR_SEL_HI = 4;
  // ==========================================================
  // Conversion lengths in converter half-clock periods
  localparam logic [5:0] HT_NORMAL = 6'd31;
  localparam logic [5:0] HT_FIRST = 6'd50;
  localparam logic [5:0] HT_AUTO = 6'd32;
  // Trigger selection code that picks the own complete flag
  localparam logic [3:0] TSEL_FREE = 4'h0;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  // ==========================================================
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } sac_apb_req_s;
  typedef enum logic {ST_IDLE, ST_CONV} sac_state_e;
endpackage : sac_pkg

// *** hdl/sac_top.sv ***
// The implementer's own choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
// Behaviour
// - 10-bit result split, right or left adjusted
// - low byte read locks result updates
// - high byte read unlocks result updates
// - complete flag set even for discarded results
// - start bit begins conversion, cleared when done except in free running
// - channel change waits for running conversion
// - auto trigger uses selected trigger source
// - trigger rising edge resets prescaler, starts
// - held-high trigger needs a fresh edge
// - trigger edges during conversion are ignored
// - source flags set regardless of enables
// - own complete flag as trigger: free running
// - free running ignores complete flag clearing
// - start bit works with auto trigger enabled
// - start bit reads one during any conversion
// - reference always applies; converter needs enable
// - input select picks pins, ground, bandgap
// - normal 15.5 cycles, first 25 cycles
// - completion writes unlocked result, flag, clears start unless free running
// - prescaler runs when enabled, else held reset
// - selections buffered, frozen during conversion
module sac_top #(
  parameter int TRIG_N = 16,
  parameter int DATA_W = 10
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  // APB slave
  input wire sac_pkg::sac_apb_req_s i_apb,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // Analog front end
  input wire logic [DATA_W-1:0] i_sar_data,
  input wire logic [TRIG_N-1:0] i_trig,
  output logic o_analog_en,
  output logic o_sample,
  output logic [4:0] o_input_sel,
  output logic [1:0] o_ref_sel,
  // Status
  output logic o_busy,
  output logic o_complete_irq
);
  import sac_pkg::*;

  // ==========================================================
  // Registers
  sac_state_e st_q;
  logic en_q, auto_q, flag_q, ie_q, ladj_q, lock_q, first_q, trig_conv_q;
  logic [2:0] div_q;
  logic [3:0] tsel_q;
  logic [4:0] sel_sw_q;
  logic [1:0] ref_sw_q;
  logic [5:0] presc_q, cnt_q;
  logic [DATA_W-1:0] res_q, sar_m_q, sar_s_q;
  logic [TRIG_N-1:0] trig_m_q, trig_s_q;
  logic trig_prev_q;

  // ==========================================================
  // APB decode; access phase is answered one cycle late so that
  // read data can come straight from a flop
  wire acc = i_apb.psel && i_apb.penable;
  wire done_acc = acc && o_pready;
  wire wr = done_acc && i_apb.pwrite;
  wire rd = done_acc && !i_apb.pwrite;
  wire hit_a = i_apb.paddr == OFS_CTRL_A;
  wire hit_b = i_apb.paddr == OFS_CTRL_B;
  wire hit_cr = i_apb.paddr == OFS_CHREF;
  wire hit_lo = i_apb.paddr == OFS_RES_LO;
  wire hit_hi = i_apb.paddr == OFS_RES_HI;
  wire mapped = hit_a || hit_b || hit_cr || hit_lo || hit_hi;
  wire [7:0] wd = i_apb.pwdata[7:0];
  wire wr_a = wr && hit_a;

  // ==========================================================
  // Prescaler: half-period of the converter clock in i_clk cycles
  wire [5:0] mask = (div_q <= 3'd1) ? 6'h00 : 6'((7'h01 << (div_q - 3'd1)) - 7'h01);
  wire tick = en_q && ((presc_q & mask) == mask);

  // Trigger edge detection on the synchronised selected source
  wire trig_lvl = (tsel_q == TSEL_FREE) ? flag_q : trig_s_q[tsel_q];
  wire trig_edge = trig_lvl && !trig_prev_q;
  wire busy = st_q == ST_CONV;
  wire sw_start = wr_a && wd[CA_START] && en_q;
  wire trig_start = en_q && auto_q && !busy && trig_edge && !sw_start;
  wire start = !busy && (sw_start || trig_start);
  wire [5:0] len = first_q ? HT_FIRST : (trig_conv_q ? HT_AUTO : HT_NORMAL);
  wire done = busy && tick && (cnt_q == len - 6'd1);
  wire free_run = auto_q && (tsel_q == TSEL_FREE);
  wire restart = done && free_run;
  wire flag_clr = wr_a && wd[CA_FLAG];

  // Result formatting follows left_adjust at read time
  wire [7:0] res_lo = ladj_q ? {res_q[1:0], 6'h00} : res_q[7:0];
  wire [7:0] res_hi = ladj_q ? res_q[9:2] : {6'h00, res_q[9:8]};
  wire [7:0] rd_a = {en_q, busy, auto_q, flag_q, ie_q, div_q};
  wire [7:0] rd_cr = {ref_sw_q, ladj_q, sel_sw_q};
  wire [7:0] rd_byte = hit_a ? rd_a : hit_b ? {4'h0, tsel_q} : hit_cr ? rd_cr :
                       hit_lo ? res_lo : hit_hi ? res_hi : RESET_BYTE;

  // ==========================================================
  // Input synchronisers: first stage only feeds the second
  always_ff @(posedge i_clk)
  begin
    if (!i_resetn)
    begin
      trig_m_q <= '0;
      trig_s_q <= '0;
      sar_m_q <= '0;
      sar_s_q <= '0;
    end
    else
    begin
      trig_m_q <= i_trig;
      trig_s_q <= trig_m_q;
      sar_m_q <= i_sar_data;
      sar_s_q <= sar_m_q;
    end
  end

  // Bus answer flops
  always_ff @(posedge i_clk)
  begin
    if (!i_resetn)
    begin
      o_pready <= 1'b0;
      o_prdata <= '0;
      o_pslverr <= 1'b0;
    end
    else
    begin
      o_pready <= acc && !o_pready;
      o_prdata <= {24'h000000, rd_byte};
      o_pslverr <= acc && !o_pready && !mapped;
    end
  end

  // Software-written configuration
  always_ff @(posedge i_clk)
  begin
    if (!i_resetn)
    begin
      {en_q, auto_q, ie_q, ladj_q} <= '0;
      div_q <= '0;
      tsel_q <= '0;
      sel_sw_q <= '0;
      ref_sw_q <= '0;
    end
    else
    begin
      if (wr_a)
      begin
        en_q <= wd[CA_EN];
        auto_q <= wd[CA_AUTO];
        ie_q <= wd[CA_IE];
        div_q <= wd[CA_DIV_HI:0];
      end
      if (wr && hit_b)
        tsel_q <= wd[3:0];
      if (wr && hit_cr)
      begin
        ref_sw_q <= wd[CR_REF_HI:CR_REF_LO];
        ladj_q <= wd[CR_LADJ];
        sel_sw_q <= wd[CR_SEL_HI:0];
      end
    end
  end

  // Prescaler held at zero while disabled, restarted by a trigger
  always_ff @(posedge i_clk)
  begin
    if (!i_resetn || !en_q || trig_start)
      presc_q <= '0;
    else
      presc_q <= presc_q + 6'd1;
  end

  // Conversion sequencer
  always_ff @(posedge i_clk)
  begin
    if (!i_resetn || !en_q)
    begin
      st_q <= ST_IDLE;
      cnt_q <= '0;
      trig_conv_q <= 1'b0;
    end
    else
    begin
      case (st_q)
        ST_IDLE:
        begin
          cnt_q <= '0;
          if (start)
          begin
            st_q <= ST_CONV;
            trig_conv_q <= trig_start;
          end
        end
        ST_CONV:
        begin
          if (done)
          begin
            cnt_q <= '0;
            trig_conv_q <= 1'b0;
            if (!restart)
              st_q <= ST_IDLE;
          end
          else if (tick)
            cnt_q <= cnt_q + 6'd1;
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  // Flag, lock, result and first-conversion tracking.
  // The set of the flag beats a simultaneous software clear.
  always_ff @(posedge i_clk)
  begin
    if (!i_resetn)
    begin
      flag_q <= 1'b0;
      lock_q <= 1'b0;
      first_q <= 1'b1;
      res_q <= '0;
      trig_prev_q <= 1'b0;
    end
    else
    begin
      trig_prev_q <= trig_lvl;
      if (done)
        flag_q <= 1'b1;
      else if (flag_clr)
        flag_q <= 1'b0;
      if (rd && hit_hi)
        lock_q <= 1'b0;
      else if (rd && hit_lo)
        lock_q <= 1'b1;
      if (done && !lock_q)
        res_q <= sar_s_q;
      if (!en_q)
        first_q <= 1'b1;
      else if (done)
        first_q <= 1'b0;
    end
  end

  // Analog-facing outputs; selection buffer follows software while idle
  always_ff @(posedge i_clk)
  begin
    if (!i_resetn)
    begin
      o_input_sel <= '0;
      o_ref_sel <= '0;
      o_analog_en <= 1'b0;
      o_sample <= 1'b0;
      o_busy <= 1'b0;
      o_complete_irq <= 1'b0;
    end
    else
    begin
      // Reference follows software while idle even when disabled, frozen mid-conversion
      if (!busy || done)
      begin
        o_ref_sel <= ref_sw_q;
        o_input_sel <= sel_sw_q;
      end
      o_analog_en <= en_q;
      o_sample <= start || restart;
      o_busy <= start || (busy && !(done && !restart));
      o_complete_irq <= (flag_q || done) && ie_q;
    end
  end

  // ==========================================================
  // Checks
  sequence seq_done;
    busy && tick && (cnt_q == len - 6'd1);
  endsequence
  sequence seq_idle_start;
    !busy && en_q && wr_a && wd[CA_START];
  endsequence

  AST_START_RUNS: assert property (@(posedge i_clk) disable iff (!i_resetn)
    seq_idle_start |=> busy ##1 o_busy)
    else $error("start write did not begin conversion");
  AST_ZERO_NOP: assert property (@(posedge i_clk) disable iff (!i_resetn)
    !busy && wr_a && !wd[CA_START] && !trig_start |=> !busy)
    else $error("zero start write began conversion");
  AST_SINGLE_END: assert property (@(posedge i_clk) disable iff (!i_resetn)
    seq_done and !free_run |=> !busy && flag_q)
    else $error("single conversion did not end with flag");
  AST_LOCKED: assert property (@(posedge i_clk) disable iff (!i_resetn)
    lock_q && !(rd && hit_hi) |=> $stable(res_q))
    else $error("result changed while locked");
  AST_UNLOCK: assert property (@(posedge i_clk) disable iff (!i_resetn)
    rd && hit_hi |=> !lock_q)
    else $error("high byte read did not unlock");
  AST_FLAG_DISCARD: assert property (@(posedge i_clk) disable iff (!i_resetn)
    seq_done ##0 lock_q |=> flag_q && $stable(res_q))
    else $error("locked completion mishandled");
  AST_FROZEN_SEL: assert property (@(posedge i_clk) disable iff (!i_resetn)
    busy && $past(busy) && !$past(done) |-> $stable(o_input_sel) && $stable(o_ref_sel))
    else $error("input select moved mid conversion");
  AST_FREE_RUN: assert property (@(posedge i_clk) disable iff (!i_resetn)
    seq_done and free_run and en_q |=> busy [*2])
    else $error("free running stopped");
  AST_NO_RETRIG: assert property (@(posedge i_clk) disable iff (!i_resetn)
    busy && en_q && trig_edge && !done |=> busy && presc_q == $past(presc_q) + 6'd1)
    else $error("edge disturbed conversion");
  AST_PRESC_HELD: assert property (@(posedge i_clk) disable iff (!i_resetn)
    !en_q |=> presc_q == 6'h00 && !busy)
    else $error("prescaler ran while disabled");
  AST_TRIG_RESET: assert property (@(posedge i_clk) disable iff (!i_resetn)
    trig_start |=> presc_q == 6'h00 && busy && trig_conv_q)
    else $error("trigger did not reset prescaler");
endmodule : sac_top

// *** tb/tb.sv ***
`timescale 1ns/1ps
module tb;
  import sac_pkg::*;
  // ==========================================================
  // Stimulus and observed signals
  logic i_clk;
  logic i_resetn;
  sac_apb_req_s apb;
  logic [31:0] o_prdata;
  logic [31:0] rd;
  logic o_pready, o_pslverr, o_analog_en, o_sample, o_busy, o_complete_irq, err;
  logic [9:0] sar;
  logic [15:0] trig;
  logic [4:0] o_input_sel;
  logic [1:0] o_ref_sel;
  int n_fail, total_checks, cyc, busy_run, last_run, n_smp, n0;

  sac_top dut (.i_clk(i_clk), .i_resetn(i_resetn), .i_apb(apb), .o_prdata(o_prdata),
    .o_pready(o_pready), .o_pslverr(o_pslverr), .i_sar_data(sar), .i_trig(trig),
    .o_analog_en(o_analog_en), .o_sample(o_sample), .o_input_sel(o_input_sel),
    .o_ref_sel(o_ref_sel), .o_busy(o_busy), .o_complete_irq(o_complete_irq));

  initial
  begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end

  // Busy length, start pulses and a cycle ceiling against hangs
  always @(posedge i_clk)
  begin
    cyc <= cyc + 1;
    if (o_busy === 1'b1) busy_run <= busy_run + 1;
    else if (busy_run != 0)
    begin
      last_run <= busy_run;
      busy_run <= 0;
    end
    if (o_sample === 1'b1) n_smp <= n_smp + 1;
    if (cyc == 20000)
    begin
      n_fail++;
      tally_and_finish();
    end
  end

  // ==========================================================
  // Tasks
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // One APB transfer; request held until pready is sampled high
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
    apb <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge i_clk);
    apb.penable <= 1'b1;
    // No local limit: only the bench ceiling ends a stuck wait
    do
      @(posedge i_clk);
    while (o_pready !== 1'b1);
    rd = o_prdata;
    err = o_pslverr;
    apb <= '0;
    @(posedge i_clk);
  endtask : xfer

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(a, 1'b1, d);
  endtask : wr

  task automatic rdc(input logic [7:0] a, input string nm, input logic [31:0] exp);
    xfer(a, 1'b0, 32'h0);
    chk(nm, rd, exp);
  endtask : rdc

  // Bounded wait; o_busy lags the start by one edge
  task automatic wait_done();
    int n;
    n = 0;
    repeat (3) @(posedge i_clk);
    while (o_busy === 1'b1 && n < 300)
    begin
      @(posedge i_clk);
      n++;
    end
    repeat (2) @(posedge i_clk);
  endtask : wait_done

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : tally_and_finish

  // ==========================================================
  // Main sequence
  initial
  begin
    i_resetn = 1'b0;
    apb = '0;
    sar = 10'h2a5;
    trig = '0;
    repeat (8) @(posedge i_clk);
    i_resetn <= 1'b1;
    @(posedge i_clk);
    rdc(OFS_CTRL_A, "ctrl_a reset", 32'h0);
    rdc(8'h40, "unmapped read", 32'h0);
    chk("pslverr", {31'h0, err}, 32'h1);
    // Selections follow writes while idle, even with the converter off
    wr(OFS_CHREF, 32'hc5);
    repeat (2) @(posedge i_clk);
    chk("ref_sel", {30'h0, o_ref_sel}, 32'h3);
    chk("input_sel idle", {27'h0, o_input_sel}, 32'h5);
    chk("analog_en off", {31'h0, o_analog_en}, 32'h0);
    wr(OFS_CTRL_A, 32'h80);
    repeat (4) @(posedge i_clk);
    chk("zero start", n_smp, 0);
    // First conversion with interrupt enable, channel changed mid-way
    wr(OFS_CTRL_A, 32'hc8);
    rdc(OFS_CTRL_A, "start busy", 32'hc8);
    wr(OFS_CHREF, 32'h07);
    chk("input_sel frozen", {27'h0, o_input_sel}, 32'h5);
    chk("ref_sel frozen", {30'h0, o_ref_sel}, 32'h3);
    wait_done();
    chk("ref_sel after", {30'h0, o_ref_sel}, 32'h0);
    chk("first length", last_run, 50);
    chk("input_sel after", {27'h0, o_input_sel}, 32'h7);
    chk("irq", {31'h0, o_complete_irq}, 32'h1);
    rdc(OFS_CTRL_A, "done ctrl", 32'h98);
    // Low read locks; the next result is dropped but still flagged
    rdc(OFS_RES_LO, "low a", 32'ha5);
    sar <= 10'h15a;
    wr(OFS_CTRL_A, 32'hd8);
    wait_done();
    chk("normal length", last_run, 31);
    rdc(OFS_CTRL_A, "flag dropped", 32'h98);
    rdc(OFS_RES_HI, "high a", 32'h02);
    rdc(OFS_RES_LO, "low kept", 32'ha5);
    rdc(OFS_RES_HI, "unlock", 32'h02);
    wr(OFS_CTRL_A, 32'hd8);
    wait_done();
    rdc(OFS_RES_LO, "low c", 32'h5a);
    wr(OFS_CHREF, 32'h27);
    rdc(OFS_RES_LO, "low left", 32'h80);
    rdc(OFS_RES_HI, "high left", 32'h56);
    // Trigger edge, edge during conversion, level held afterwards
    wr(OFS_CTRL_B, 32'h3);
    wr(OFS_CTRL_A, 32'hb0);
    n0 = n_smp;
    trig[3] <= 1'b1;
    repeat (12) @(posedge i_clk);
    trig[3] <= 1'b0;
    repeat (3) @(posedge i_clk);
    trig[3] <= 1'b1;
    wait_done();
    chk("auto length", last_run, 32);
    repeat (40) @(posedge i_clk);
    chk("trigger count", n_smp - n0, 1);
    wr(OFS_CTRL_A, 32'he0);
    wait_done();
    chk("start in auto", n_smp - n0, 2);
    // Free running on the own complete flag, flag cleared mid-run
    trig[3] <= 1'b0;
    wr(OFS_CTRL_B, 32'h0);
    n0 = n_smp;
    wr(OFS_CTRL_A, 32'he0);
    repeat (60) @(posedge i_clk);
    wr(OFS_CTRL_A, 32'hf0);
    repeat (60) @(posedge i_clk);
    chk("free run", 32'(n_smp - n0 >= 3), 32'h1);
    rdc(OFS_CTRL_A, "free start bit", 32'hf0);
    // Switching the converter off stops free running
    wr(OFS_CTRL_A, 32'h00);
    repeat (2) @(posedge i_clk);
    chk("analog_en end", {31'h0, o_analog_en}, 32'h0);
    chk("busy end", {31'h0, o_busy}, 32'h0);
    tally_and_finish();
  end
endmodule : tb
